/* File: hpw_pkg.sv */
// hpw_pkg: shared constants and types of the host power watchdog
package hpw_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets on the byte register port
  localparam logic [7:0] OFS_BOOT_TIMEOUT = 8'h15; // boot phase limit, 10 s units
  localparam logic [7:0] OFS_SHUTDOWN_TIMEOUT = 8'h16; // shutdown phase limit, 10 s units
  localparam logic [7:0] OFS_GUARD_CONFIG = 8'h17; // countdown action select
  localparam logic [7:0] OFS_GUARD_GRACE = 8'h18; // countdown value loaded at boot report
  localparam logic [7:0] OFS_GUARD_COUNTDOWN = 8'h1C; // live countdown, volatile
  localparam logic [7:0] OFS_HOST_RUNNING_FLAG = 8'h1D; // host-running flag

  //////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RST_BOOT_TIMEOUT = 8'h1E; // 30 units, five minutes
  localparam logic [7:0] RST_SHUTDOWN_TIMEOUT = 8'h0C; // 12 units, two minutes
  localparam logic [7:0] RST_GUARD_CONFIG = 8'h00; // countdown off
  localparam logic [7:0] RST_GUARD_GRACE = 8'h02; // 2 units, twenty seconds
  localparam logic [7:0] RST_GUARD_COUNTDOWN = 8'h00; // empty until first boot report

  //////////////////////////////////////////////////////////////////////////////
  // countdown action codes
  localparam logic [7:0] CFG_GUARD_OFF = 8'h00; // frozen, no action
  localparam logic [7:0] CFG_GUARD_ALERT = 8'h01; // fast error flash on expiry
  localparam logic [7:0] CFG_GUARD_SHUTDOWN_MODE = 8'h02; // clean host shutdown on expiry

  // field position of the host-running flag in its byte
  localparam int RUN_FLAG_BIT = 0;

  // length of one timeout unit in seconds, and slow ticks that make it
  localparam int UNIT_SECONDS = 10;
  localparam int DEF_TICKS_PER_UNIT = 50; // plain default, real tick rate drifts widely
  localparam int TICK_CNT_W = 16; // width of the slow tick prescaler

  // host power phases
  typedef enum logic [1:0] {
    ST_OFF,
    ST_BOOT,
    ST_RUN,
    ST_SHDN
  } hpw_state_e;

  // power indicator drive patterns
  typedef enum logic [1:0] {
    LED_DARK,
    LED_PULSE,
    LED_STEADY,
    LED_ERROR_FLASH
  } hpw_led_e;

endpackage : hpw_pkg

/* File: hpw_cnt_if.sv */
// hpw_cnt_if: bundle between the control logic, a prescaler and a countdown
`timescale 1ns/1ps
`default_nettype none

interface hpw_cnt_if;
  logic load; // restart countdown from load_val
  logic [7:0] load_val; // value to load, 10 s units
  logic rearm; // allow a new expiry without reloading
  logic run; // countdown enabled
  logic unit; // one pulse per elapsed 10 s unit
  logic [7:0] count; // present countdown value
  logic expired; // one-cycle pulse when count is spent

  modport ctl (output load, output load_val, output rearm, output run,
               input count, input expired);
  modport cnt (input load, input load_val, input rearm, input run, input unit,
               output count, output expired);
  modport pre (input load, input run, output unit);
endinterface : hpw_cnt_if

`default_nettype wire

/* File: hpw_prescale.sv */
// hpw_prescale: turns slow system ticks into 10 second unit pulses
`timescale 1ns/1ps
`default_nettype none

module hpw_prescale #(
  parameter int TICKS_PER_UNIT = hpw_pkg::DEF_TICKS_PER_UNIT
) (
  input wire logic ref_clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sys_tick, // one-cycle slow tick pulse
  hpw_cnt_if.pre cnt // countdown control bundle
);

  // the prescaler holds at most TICK_CNT_W bits
  if (TICKS_PER_UNIT < 1 || TICKS_PER_UNIT > 65535) begin : g_bad_ticks
    $error("hpw_prescale: TICKS_PER_UNIT out of range");
  end

  localparam logic [15:0] LAST_TICK = 16'(TICKS_PER_UNIT - 1);

  logic [15:0] tick_cnt_r; // ticks seen in this unit
  logic [15:0] tick_cnt_nxt;
  logic unit_r; // unit pulse register
  logic unit_nxt;

  // a load restarts the unit so the first unit after a write is whole
  always_comb begin
    tick_cnt_nxt = tick_cnt_r;
    unit_nxt = 1'b0;
    if (cnt.load || !cnt.run) begin
      tick_cnt_nxt = 16'h0000;
    end else if (sys_tick) begin
      if (tick_cnt_r == LAST_TICK) begin
        tick_cnt_nxt = 16'h0000;
        unit_nxt = 1'b1;
      end else begin
        tick_cnt_nxt = tick_cnt_r + 16'h0001;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt_r <= 16'h0000;
      unit_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      unit_r <= unit_nxt;
    end
  end

  assign cnt.unit = unit_r;

endmodule : hpw_prescale

`default_nettype wire

/* File: hpw_countdown.sv */
// hpw_countdown: byte countdown in 10 second units with one-shot expiry
`timescale 1ns/1ps
`default_nettype none

module hpw_countdown #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic ref_clk, // block clock
  input wire logic rst_n, // synchronous reset, active low
  hpw_cnt_if.cnt cnt // countdown bundle
);

  logic [7:0] count_r; // remaining units
  logic [7:0] count_nxt;
  logic fired_r; // expiry already reported
  logic fired_nxt;
  logic expired_r; // expiry pulse
  logic expired_nxt;

  // load wins over counting; zero holds and reports once per load or rearm
  always_comb begin
    count_nxt = count_r;
    fired_nxt = fired_r && !cnt.rearm; // rearm must not swallow a unit pulse
    expired_nxt = 1'b0;
    if (cnt.load) begin
      count_nxt = cnt.load_val;
      fired_nxt = 1'b0;
    end else if (cnt.run) begin
      if (count_r == 8'h00) begin
        if (!fired_r) begin
          expired_nxt = 1'b1;
          fired_nxt = 1'b1;
        end
      end else if (cnt.unit) begin
        count_nxt = count_r - 8'h01;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_r <= RESET_VAL;
      fired_r <= 1'b0;
      expired_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      fired_r <= fired_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign cnt.count = count_r;
  assign cnt.expired = expired_r;

endmodule : hpw_countdown

`default_nettype wire

/* File: hpw_watchdog.sv */
// hpw_watchdog: boot, shutdown and application countdown supervision of host power
//
// Overview of operation
// (RULE1) boot timeout byte, 10 s units, default 30
// (RULE2) boot never reported: power off at timeout
// (RULE3) shutdown timeout byte, 10 s units, default 12
// (RULE4) serial line stays high: power off at timeout
// (RULE5) all timeouts span full byte, 10 s steps
// (RULE6) low serial transmit line means kernel halted
// (RULE7) countdown drops every 10 s, acts at zero
// (RULE8) configuration zero freezes countdown, no action
// (RULE9) alert mode: zero forces fast error flash
// (RULE10) shutdown mode: zero starts a normal shutdown
// (RULE11) boot report loads countdown with grace, default 2
// (RULE12) countdown write restarts counting from written value
// (RULE13) countdown byte readable, writable and volatile
// (RULE14) host application rewrites countdown before it expires
// (RULE15) running flag reads zero when off or booting
// (RULE16) running flag set: steady indicator, touch-off allowed
// (RULE17) running flag cleared: shutdown with pulsing indicator
// (RULE18) battery below minimum: power removed at once
// (RULE19) countdown saturates, acts once until rewritten
`timescale 1ns/1ps
`default_nettype none

module hpw_watchdog #(
  parameter int TICKS_PER_UNIT = hpw_pkg::DEF_TICKS_PER_UNIT // slow ticks per 10 s
) (
  input wire logic ref_clk, // 250 MHz block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sys_tick, // slow system tick, one-cycle pulse
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, registered
  input wire logic power_on_req, // boot request from touch pad or auto boot
  input wire logic shutdown_req, // shutdown request from touch pad or low battery
  input wire logic vbat_below_min, // battery under the minimum threshold
  input wire logic host_tx_line, // host serial transmit pin, asynchronous
  output logic host_power_en, // host supply switch on
  output logic [1:0] power_indicator, // indicator pattern code
  output logic touch_off_en, // touch-off requests accepted
  output logic guard_alert // countdown alert active
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  // configuration registers
  logic [7:0] boot_timeout_r; // boot phase limit
  logic [7:0] boot_timeout_nxt;
  logic [7:0] shutdown_timeout_r; // shutdown phase limit
  logic [7:0] shutdown_timeout_nxt;
  logic [7:0] guard_config_r; // countdown action
  logic [7:0] guard_config_nxt;
  logic [7:0] guard_grace_r; // countdown start value
  logic [7:0] guard_grace_nxt;

  // phase state and outputs
  hpw_pkg::hpw_state_e state_r; // host power phase
  hpw_pkg::hpw_state_e state_nxt;
  logic alert_r; // error flash latched
  logic alert_nxt;
  logic host_power_en_r; // supply switch register
  logic host_power_en_nxt;
  logic [1:0] led_r; // indicator code register
  logic [1:0] led_nxt;
  logic touch_off_en_r; // touch-off gate register
  logic touch_off_en_nxt;
  logic [7:0] rdata_r; // read data register
  logic [7:0] rdata_nxt;

  // serial line synchroniser
  logic tx_meta_r; // first stage, read only by the second
  logic tx_sync_r; // second stage, safe to use

  // decoded writes
  logic wr_boot_to; // boot timeout written
  logic wr_shdn_to; // shutdown timeout written
  logic wr_cfg; // countdown configuration written
  logic wr_grace; // grace written
  logic wr_countdown; // countdown written
  logic wr_flag; // running flag written
  logic flag_set; // flag written with one
  logic flag_clear; // flag written with zero

  // countdown controls
  logic phase_load; // start a phase timeout
  logic [7:0] phase_val; // phase timeout value
  logic grace_load; // boot report loads grace

  hpw_cnt_if phase_if (); // boot and shutdown phase timer
  hpw_cnt_if guard_if (); // application countdown

  //////////////////////////////////////////////////////////////////////////////
  // submodules

  hpw_prescale #(
    .TICKS_PER_UNIT(TICKS_PER_UNIT)
  ) u_phase_pre (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sys_tick(sys_tick),
    .cnt(phase_if.pre)
  );

  hpw_countdown #(
    .RESET_VAL(8'h00)
  ) u_phase_cnt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cnt(phase_if.cnt)
  );

  hpw_prescale #(
    .TICKS_PER_UNIT(TICKS_PER_UNIT)
  ) u_guard_pre (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sys_tick(sys_tick),
    .cnt(guard_if.pre)
  );

  hpw_countdown #(
    .RESET_VAL(hpw_pkg::RST_GUARD_COUNTDOWN)
  ) u_guard_cnt (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cnt(guard_if.cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial line synchroniser, the pin is not on this clock

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_meta_r <= 1'b1;
      tx_sync_r <= 1'b1;
    end else begin
      tx_meta_r <= host_tx_line;
      tx_sync_r <= tx_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register write decode

  always_comb begin
    wr_boot_to = reg_wr && (reg_addr == hpw_pkg::OFS_BOOT_TIMEOUT);
    wr_shdn_to = reg_wr && (reg_addr == hpw_pkg::OFS_SHUTDOWN_TIMEOUT);
    wr_cfg = reg_wr && (reg_addr == hpw_pkg::OFS_GUARD_CONFIG);
    wr_grace = reg_wr && (reg_addr == hpw_pkg::OFS_GUARD_GRACE);
    wr_countdown = reg_wr && (reg_addr == hpw_pkg::OFS_GUARD_COUNTDOWN);
    wr_flag = reg_wr && (reg_addr == hpw_pkg::OFS_HOST_RUNNING_FLAG);
    flag_set = wr_flag && reg_wdata[hpw_pkg::RUN_FLAG_BIT];
    flag_clear = wr_flag && !reg_wdata[hpw_pkg::RUN_FLAG_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers, full byte each, no range limit

  always_comb begin
    boot_timeout_nxt = wr_boot_to ? reg_wdata : boot_timeout_r; // RULE1 RULE5
    shutdown_timeout_nxt = wr_shdn_to ? reg_wdata : shutdown_timeout_r; // RULE3 RULE5
    guard_config_nxt = wr_cfg ? reg_wdata : guard_config_r;
    guard_grace_nxt = wr_grace ? reg_wdata : guard_grace_r; // RULE5
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      boot_timeout_r <= hpw_pkg::RST_BOOT_TIMEOUT; // RULE1
      shutdown_timeout_r <= hpw_pkg::RST_SHUTDOWN_TIMEOUT; // RULE3
      guard_config_r <= hpw_pkg::RST_GUARD_CONFIG;
      guard_grace_r <= hpw_pkg::RST_GUARD_GRACE; // RULE11
    end else begin
      boot_timeout_r <= boot_timeout_nxt;
      shutdown_timeout_r <= shutdown_timeout_nxt;
      guard_config_r <= guard_config_nxt;
      guard_grace_r <= guard_grace_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host power phase machine
  // low battery is checked first in every powered phase: it must not wait
  // for a clean shutdown that may never come

  always_comb begin
    state_nxt = state_r;
    phase_load = 1'b0;
    phase_val = boot_timeout_r;
    grace_load = 1'b0;
    case (state_r)
      hpw_pkg::ST_OFF: begin
        // booting on a flat battery would only trip the cutoff again
        if (power_on_req && !vbat_below_min) begin
          state_nxt = hpw_pkg::ST_BOOT;
          phase_load = 1'b1; // RULE2
          phase_val = boot_timeout_r;
        end
      end
      hpw_pkg::ST_BOOT: begin
        if (vbat_below_min) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE18
        end else if (phase_if.expired) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE2
        end else if (flag_set) begin
          state_nxt = hpw_pkg::ST_RUN; // RULE16
          grace_load = 1'b1; // RULE11
        end
      end
      hpw_pkg::ST_RUN: begin
        if (vbat_below_min) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE18
        end else if (flag_clear || shutdown_req) begin
          state_nxt = hpw_pkg::ST_SHDN; // RULE17
          phase_load = 1'b1;
          phase_val = shutdown_timeout_r;
        end else if (guard_if.expired &&
                     guard_config_r == hpw_pkg::CFG_GUARD_SHUTDOWN_MODE) begin
          state_nxt = hpw_pkg::ST_SHDN; // RULE10
          phase_load = 1'b1; // RULE10
          phase_val = shutdown_timeout_r;
        end
      end
      hpw_pkg::ST_SHDN: begin
        if (vbat_below_min) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE18
        end else if (!tx_sync_r) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE6
        end else if (phase_if.expired) begin
          state_nxt = hpw_pkg::ST_OFF; // RULE4
        end
      end
      default: begin
        state_nxt = hpw_pkg::ST_OFF;
      end
    endcase
  end

  // phase timer runs only while a phase is being timed
  always_comb begin
    phase_if.load = phase_load;
    phase_if.load_val = phase_val;
    phase_if.rearm = 1'b0;
    phase_if.run = (state_r == hpw_pkg::ST_BOOT) || (state_r == hpw_pkg::ST_SHDN);
  end

  //////////////////////////////////////////////////////////////////////////////
  // application countdown control
  // a write stores the value even while disabled, so a value set before
  // enabling is not lost; it only starts counting once enabled

  always_comb begin
    guard_if.load = grace_load || wr_countdown; // RULE11 RULE12
    guard_if.load_val = wr_countdown ? reg_wdata : guard_grace_r; // RULE12
    guard_if.rearm = wr_cfg; // RULE19
    guard_if.run = (guard_config_r != hpw_pkg::CFG_GUARD_OFF) &&
                   (state_r == hpw_pkg::ST_RUN); // RULE8 RULE7
  end

  //////////////////////////////////////////////////////////////////////////////
  // alert latch; power off clears it with the supply, else expiry beats a clear

  always_comb begin
    alert_nxt = alert_r;
    if (state_nxt == hpw_pkg::ST_OFF) begin
      alert_nxt = 1'b0; // RULE19
    end else if (guard_if.expired && guard_config_r == hpw_pkg::CFG_GUARD_ALERT) begin
      alert_nxt = 1'b1; // RULE9
    end else if (wr_countdown || wr_cfg) begin
      alert_nxt = 1'b0; // RULE19
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output decode from the next phase, so outputs settle with the state

  always_comb begin
    host_power_en_nxt = (state_nxt != hpw_pkg::ST_OFF); // RULE18
    touch_off_en_nxt = (state_nxt == hpw_pkg::ST_RUN); // RULE16
    case (state_nxt)
      hpw_pkg::ST_OFF: led_nxt = hpw_pkg::LED_DARK;
      hpw_pkg::ST_BOOT: led_nxt = hpw_pkg::LED_PULSE;
      hpw_pkg::ST_RUN: begin
        // the error flash overrides the steady pattern
        led_nxt = alert_nxt ? hpw_pkg::LED_ERROR_FLASH : hpw_pkg::LED_STEADY; // RULE9 RULE16
      end
      hpw_pkg::ST_SHDN: led_nxt = hpw_pkg::LED_PULSE; // RULE17
      default: led_nxt = hpw_pkg::LED_DARK;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read mux, unmapped offsets read as zero

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        hpw_pkg::OFS_BOOT_TIMEOUT: rdata_nxt = boot_timeout_r;
        hpw_pkg::OFS_SHUTDOWN_TIMEOUT: rdata_nxt = shutdown_timeout_r;
        hpw_pkg::OFS_GUARD_CONFIG: rdata_nxt = guard_config_r;
        hpw_pkg::OFS_GUARD_GRACE: rdata_nxt = guard_grace_r;
        hpw_pkg::OFS_GUARD_COUNTDOWN: rdata_nxt = guard_if.count; // RULE13
        hpw_pkg::OFS_HOST_RUNNING_FLAG: begin
          // only a booted, running host reads one
          rdata_nxt = {7'h00, state_r == hpw_pkg::ST_RUN}; // RULE15
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and output registers

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= hpw_pkg::ST_OFF;
      alert_r <= 1'b0;
      host_power_en_r <= 1'b0;
      led_r <= hpw_pkg::LED_DARK;
      touch_off_en_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      alert_r <= alert_nxt;
      host_power_en_r <= host_power_en_nxt;
      led_r <= led_nxt;
      touch_off_en_r <= touch_off_en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign host_power_en = host_power_en_r;
  assign power_indicator = led_r;
  assign touch_off_en = touch_off_en_r;
  assign guard_alert = alert_r;
  assign reg_rdata = rdata_r;

endmodule : hpw_watchdog

`default_nettype wire

/* File: hpw_host_model.sv */
// hpw_host_model: behavioural host whose serial transmit line falls when its kernel halts
`timescale 1ns/1ps
`default_nettype none

module hpw_host_model #(
  parameter int HALT_LAG = 3 // cycles from halt command to line low
) (
  input wire logic ref_clk, // block clock
  input wire logic host_power_en, // supply from the manager
  input wire logic halt, // bench command: kernel finished
  output logic host_tx_line // serial transmit pin
);
  logic [3:0] lag_r; // cycles since halt seen
  //////////////////////////////////////////////////////////////////////////////
  // lag counter, restarts when the host loses power
  always_ff @(posedge ref_clk) begin
    if (!host_power_en || !halt) begin
      lag_r <= 4'h0;
    end else if (lag_r != 4'(HALT_LAG)) begin
      lag_r <= lag_r + 4'h1;
    end
  end
  // unpowered host cannot hold the line up, so it reads low
  assign host_tx_line = host_power_en && !(halt && lag_r == 4'(HALT_LAG));
endmodule : hpw_host_model

`default_nettype wire

/* File: hpw_watchdog_props.sv */
// hpw_watchdog_props: port-level assertions of the host power watchdog
`timescale 1ns/1ps
`default_nettype none

module hpw_watchdog_props (
  input wire logic ref_clk, // block clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic power_on_req, // boot request
  input wire logic shutdown_req, // shutdown request
  input wire logic vbat_below_min, // low battery
  input wire logic host_tx_line, // host serial line
  input wire logic host_power_en, // host supply
  input wire logic [1:0] power_indicator, // indicator code
  input wire logic touch_off_en, // host running
  input wire logic guard_alert // alert latch
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // boot start from off with a good battery
  sequence s_boot;
    !host_power_en && power_on_req && !vbat_below_min;
  endsequence
  // daemon reports the host is up
  sequence s_flag_set;
    reg_wr && reg_addr == 8'h1D && reg_wdata[0] && !vbat_below_min && !shutdown_req;
  endsequence
  // leaving run while still powered means shutdown phase
  sequence s_shdn;
    touch_off_en ##1 (!touch_off_en && host_power_en);
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_boot_pulse: assert property (s_boot |=> host_power_en && !touch_off_en &&
    power_indicator == hpw_pkg::LED_PULSE) else $error("boot start not pulsing");
  a_boot_steady: assert property (s_boot ##1 s_flag_set |=> touch_off_en &&
    power_indicator == hpw_pkg::LED_STEADY) else $error("boot report not steady");
  a_run_indicator: assert property (touch_off_en |-> host_power_en &&
    power_indicator == (guard_alert ? hpw_pkg::LED_ERROR_FLASH : hpw_pkg::LED_STEADY))
    else $error("running indicator wrong");
  a_off_quiet: assert property (!host_power_en |-> !touch_off_en && !guard_alert &&
    power_indicator == hpw_pkg::LED_DARK) else $error("off state not quiet");
  a_low_batt: assert property (vbat_below_min |=> !host_power_en)
    else $error("low battery left power on");
  a_flag_clear: assert property (touch_off_en && reg_wr && reg_addr == 8'h1D &&
    !reg_wdata[0] && !vbat_below_min |=> !touch_off_en &&
    power_indicator == hpw_pkg::LED_PULSE) else $error("flag clear no shutdown");
  a_flag_read: assert property (reg_rd && reg_addr == 8'h1D && !touch_off_en |=>
    reg_rdata == 8'h00) else $error("flag read not zero");
  a_halt_off: assert property (s_shdn ##0 (!host_tx_line)[*4] |->
    ##[0:3] !host_power_en) else $error("halted host still powered");
endmodule : hpw_watchdog_props

bind hpw_watchdog hpw_watchdog_props chk_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .power_on_req, .shutdown_req, .vbat_below_min,
  .host_tx_line, .host_power_en, .power_indicator, .touch_off_en, .guard_alert);

`default_nettype wire

/* File: tb.sv */
// tb: register-level tests of the host power watchdog
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic ref_clk = 1'b0; // 250 MHz
  logic rst_n = 1'b0; // sync reset
  logic sys_tick = 1'b0; // slow tick, every 4 cycles
  logic [1:0] tick_cnt = 2'h0; // tick divider
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, power_on_req = 1'b0, shutdown_req = 1'b0;
  logic vbat_below_min = 1'b0, halt = 1'b0, host_tx_line, host_power_en;
  logic [1:0] power_indicator; // indicator code
  logic touch_off_en, guard_alert; // run and alert outputs
  int n_fail = 0, n_tests = 0; // counters
  // reset-value table: five registers, the flag, one unmapped place
  logic [7:0] adr [0:6] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1C, 8'h1D, 8'h20};
  logic [7:0] rst_v [0:6] = '{8'h1E, 8'h0C, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  //////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  // two ticks per unit keeps a unit at 5 to 8 cycles
  always @(posedge ref_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sys_tick <= (tick_cnt == 2'h3);
  end
  hpw_watchdog #(.TICKS_PER_UNIT(2)) dut_u (.ref_clk, .rst_n, .sys_tick, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_on_req, .shutdown_req,
    .vbat_below_min, .host_tx_line, .host_power_en, .power_indicator, .touch_off_en,
    .guard_alert);
  hpw_host_model #(.HALT_LAG(3)) host_u (.ref_clk, .host_power_en, .halt, .host_tx_line);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data is valid just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  // boot request, then optionally the daemon's flag write right behind it
  task automatic boot(input logic run);
    @(posedge ref_clk);
    power_on_req <= 1'b1;
    @(posedge ref_clk);
    power_on_req <= 1'b0;
    reg_addr <= 8'h1D;
    reg_wdata <= 8'h01;
    reg_wr <= run;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1 chk(8'(host_power_en), 8'h01);
    chk(8'(touch_off_en), 8'(run));
  endtask : boot
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, n_fail);
  endtask : done
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////
  // watchdog: tests need under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(adr[i], rst_v[i]);
    done("reset_values");
    // boot never reported, full byte range accepted
    wr(8'h15, 8'hFF);
    rd(8'h15, 8'hFF);
    wr(8'h15, 8'h02);
    boot(1'b0);
    rd(8'h1D, 8'h00);
    wait_cyc(20);
    chk(8'(host_power_en), 8'h00);
    done("boot_timeout");
    // run phase, frozen countdown, then alert mode
    wr(8'h15, 8'h1E);
    boot(1'b1);
    chk(8'(power_indicator), 8'(hpw_pkg::LED_STEADY));
    rd(8'h1C, 8'h02);
    rd(8'h1D, 8'h01);
    wait_cyc(40);
    rd(8'h1C, 8'h02);
    wr(8'h17, 8'h01);
    wr(8'h1C, 8'h03);
    wait_cyc(14);
    wr(8'h1C, 8'h03);
    wait_cyc(14);
    chk(8'(guard_alert), 8'h00);
    wait_cyc(18);
    chk(8'(guard_alert), 8'h01);
    chk(8'(power_indicator), 8'(hpw_pkg::LED_ERROR_FLASH));
    rd(8'h1C, 8'h00);
    wr(8'h1C, 8'h05);
    #1 chk(8'(guard_alert), 8'h00);
    done("alert_mode");
    // shutdown mode, host never drops its line
    wr(8'h16, 8'h04);
    wr(8'h17, 8'h02);
    wr(8'h1C, 8'h01);
    wait_cyc(16);
    chk({touch_off_en, host_power_en, 4'h0, power_indicator}, 8'h41);
    wait_cyc(40);
    chk(8'(host_power_en), 8'h00);
    done("shutdown_mode");
    // flag clear with a halted host, long timeout so only the line acts
    wr(8'h16, 8'hFF);
    wr(8'h17, 8'h00);
    boot(1'b1);
    @(posedge ref_clk) halt <= 1'b1;
    wait_cyc(6);
    wr(8'h1D, 8'h00);
    #1 chk({touch_off_en, 5'h00, power_indicator}, 8'h01);
    wait_cyc(8);
    chk(8'(host_power_en), 8'h00);
    @(posedge ref_clk) halt <= 1'b0;
    done("host_halt");
    // battery collapse while running
    boot(1'b1);
    @(posedge ref_clk) vbat_below_min <= 1'b1;
    wait_cyc(1);
    chk(8'(host_power_en), 8'h00);
    @(posedge ref_clk) vbat_below_min <= 1'b0;
    done("low_battery");
    boot(1'b1);
    @(posedge ref_clk) shutdown_req <= 1'b1;
    wait_cyc(1);
    chk({6'h00, touch_off_en, host_power_en}, 8'h01);
    done("shutdown_request");
    final_report();
  end
endmodule : tb

`default_nettype wire
